// ==== spl_pkg.sv ====
package spl_pkg;

    // register byte offsets on the management interface
    localparam logic [7:0] OFF_TAG_INSERT  = 8'hC2;
    localparam logic [7:0] OFF_PWR_LED     = 8'hC3;
    localparam logic [7:0] OFF_SLEEP       = 8'hC4;
    localparam logic [7:0] OFF_VID_HOST    = 8'hC6;

    // reset values
    localparam logic [7:0] RST_TAG_INSERT  = 8'h00;
    localparam logic [7:0] RST_PWR_LED     = 8'h00;
    localparam logic [7:0] RST_SLEEP       = 8'h50;
    localparam logic [7:0] RST_VID_HOST    = 8'h00;

    // writable masks; reserved bits stay zero
    localparam logic [7:0] MASK_TAG_INSERT = 8'h3F;
    localparam logic [7:0] MASK_VID_HOST   = 8'h7B;

    // field positions in the power and indicator register
    localparam int POS_CPU_CLK_OFF   = 7;
    localparam int POS_SW_CLK_OFF    = 6;
    localparam int POS_LED_MODE      = 4;
    localparam int POS_LED_DEBUG     = 3;
    localparam int POS_PLL_OFF       = 2;
    localparam int POS_PWR_MODE      = 0;
    // field positions in the invalid vid / host register
    localparam int POS_INVALID_FWD   = 4;
    localparam int POS_RMII_CLK_INT  = 3;
    localparam int POS_HOST_MODE     = 0;

    // sleep timer unit
    localparam int SLEEP_UNIT_MS     = 20;
    localparam int CLK_MHZ           = 100;
    localparam int SLEEP_UNIT_CYCLES = SLEEP_UNIT_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        SPL_PWR_NORMAL   = 2'h0,
        SPL_PWR_ENERGY   = 2'h1,
        SPL_PWR_SOFT_OFF = 2'h2,
        SPL_PWR_SAVING   = 2'h3
    } spl_pwr_mode_t;

    typedef enum logic [1:0] {
        SPL_LED_LACT_SPEED  = 2'h0,
        SPL_LED_LINK_ACT    = 2'h1,
        SPL_LED_LACT_DUPLEX = 2'h2,
        SPL_LED_LINK_DUPLEX = 2'h3
    } spl_led_mode_t;

    // per-port link status carried to the indicator logic
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic activity;
    } spl_port_stat_t;

    // decoded controls to the switch and clocking logic
    typedef struct packed {
        logic [5:0]    tag_insert;
        logic          cpu_clk_off;
        logic          sw_clk_off;
        logic          pll_off;
        spl_pwr_mode_t pwr_mode;
        logic [2:0]    invalid_fwd;
        logic          rmii_clk_int;
        logic [1:0]    host_mode;
    } spl_ctrl_t;

endpackage

// ==== spl_led_drive.sv ====
`timescale 1ns/10ps
module spl_led_drive (
    // clock and reset
    input  wire logic                    core_clk_in,
    input  wire logic                    rst_in,
    // controls
    input  wire logic [1:0]              led_mode_in,
    input  wire logic                    led_debug_in,
    input  wire logic                    energy_stretched_in,
    input  wire logic                    device_ready_in,
    input  wire spl_pkg::spl_port_stat_t stat_in,
    // pins, low is lit
    output logic                         status_pin_a_out,
    output logic                         status_pin_b_out
);
    logic next_a;
    logic next_b;
    logic link_act;

    always_comb begin
        // activity blinks by toggling the lit link level
        link_act = stat_in.link_up & ~stat_in.activity;
        next_a   = 1'b1;
        next_b   = 1'b1;
        if (led_debug_in) begin
            next_a = ~device_ready_in;     // see RULE_08
            next_b = ~energy_stretched_in; // see RULE_08
        end else begin
            case (spl_pkg::spl_led_mode_t'(led_mode_in)) // see RULE_06
                spl_pkg::SPL_LED_LACT_SPEED: begin
                    next_a = ~link_act;
                    next_b = ~(stat_in.link_up & stat_in.speed_100); // see RULE_07
                end
                spl_pkg::SPL_LED_LINK_ACT: begin
                    next_a = ~stat_in.link_up;
                    next_b = ~(stat_in.link_up & stat_in.activity);
                end
                spl_pkg::SPL_LED_LACT_DUPLEX: begin
                    next_a = ~link_act;
                    next_b = ~(stat_in.link_up & stat_in.full_duplex); // see RULE_07
                end
                spl_pkg::SPL_LED_LINK_DUPLEX: begin
                    next_a = ~stat_in.link_up;
                    next_b = ~(stat_in.link_up & stat_in.full_duplex);
                end
                default: begin
                    next_a = 1'b1;
                    next_b = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            status_pin_a_out <= 1'b1;
            status_pin_b_out <= 1'b1;
        end else begin
            status_pin_a_out <= next_a;
            status_pin_b_out <= next_b;
        end
    end
endmodule

// ==== spl_config_regs.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// (RULE_01) bits 3..0 insert port 2/3 default tag
// (RULE_02) bits 5,4 insert port 1 default tag
// (RULE_03) bit 7 enables cpu clock tree off
// (RULE_04) bit 6 enables switch clock tree off
// (RULE_05) software uses clock-off only when idle
// (RULE_06) led mode selects pin meanings
// (RULE_07) pins low for link, 100, full duplex
// (RULE_08) debug mode shows energy and ready inverted
// (RULE_09) bit 2 enables pll power down
// (RULE_10) software uses pll-off in bypass sleep
// (RULE_11) power mode field, resets to normal
// (RULE_12) sleep period in 20 ms units, 0x50
// (RULE_13) uninterrupted no-energy period before low power
// (RULE_14) invalid vid forward ports, reset zero
// (RULE_15) host mode reset from port 2 straps
// (RULE_16) reserved bits read zero, writes ignored
// (RULE_17) writes act next clock, reset defaults
module spl_config_regs #(
    parameter int UNIT_CYCLES = spl_pkg::SLEEP_UNIT_CYCLES
) (
    // clock and reset
    input  wire logic                    core_clk_in,
    input  wire logic                    rst_in,
    // register port
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic [7:0]              reg_wdata_in,
    output logic [7:0]                   reg_rdata_out,
    output logic                         reg_hit_out,
    // straps and analog status, from pins
    input  wire logic                    port2_status_pin_a_in,
    input  wire logic                    port2_status_pin_b_in,
    input  wire logic                    energy_in,
    input  wire logic                    energy_stretched_in,
    input  wire logic                    device_ready_in,
    input  wire spl_pkg::spl_port_stat_t port_stat_in,
    // controls
    output spl_pkg::spl_ctrl_t           ctrl_out,
    output logic                         low_power_out,
    // status pins
    output logic                         status_pin_a_out,
    output logic                         status_pin_b_out
);
    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [7:0] sync1;
    logic [7:0] sync2;
    spl_pkg::spl_port_stat_t stat_sync;

    always_ff @(posedge core_clk_in) begin
        sync1 <= {port2_status_pin_b_in, port2_status_pin_a_in, energy_in, energy_stretched_in,
                  device_ready_in, 3'h0};
        sync2 <= sync1;
    end

    logic [3:0] stat1;
    logic [3:0] stat2;
    always_ff @(posedge core_clk_in) begin
        stat1 <= port_stat_in;
        stat2 <= stat1;
    end
    assign stat_sync = spl_pkg::spl_port_stat_t'(stat2);

    logic strap_b;
    logic strap_a;
    logic energy_s;
    logic energy_str_s;
    logic ready_s;
    assign strap_b      = sync2[7];
    assign strap_a      = sync2[6];
    assign energy_s     = sync2[5];
    assign energy_str_s = sync2[4];
    assign ready_s      = sync2[3];

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] tag_insert;
    logic [7:0] pwr_led;
    logic [7:0] sleep_period;
    logic [7:0] vid_host;
    logic       strap_pending;
    logic [7:0] next_tag_insert;
    logic [7:0] next_pwr_led;
    logic [7:0] next_sleep_period;
    logic [7:0] next_vid_host;
    logic       next_strap_pending;

    function automatic logic is_write(input logic wr, input logic [7:0] a, input logic [7:0] off);
        is_write = wr & (a == off);
    endfunction

    always_comb begin
        next_tag_insert    = tag_insert;
        next_pwr_led       = pwr_led;
        next_sleep_period  = sleep_period;
        next_vid_host      = vid_host;
        next_strap_pending = 1'b0;
        if (is_write(reg_wr_in, reg_addr_in, spl_pkg::OFF_TAG_INSERT)) begin
            next_tag_insert = reg_wdata_in & spl_pkg::MASK_TAG_INSERT; // see RULE_01 see RULE_02 see RULE_16
        end
        if (is_write(reg_wr_in, reg_addr_in, spl_pkg::OFF_PWR_LED)) begin
            next_pwr_led = reg_wdata_in; // see RULE_17
        end
        if (is_write(reg_wr_in, reg_addr_in, spl_pkg::OFF_SLEEP)) begin
            next_sleep_period = reg_wdata_in; // see RULE_12
        end
        if (strap_pending) begin
            // straps are taken once the synchronisers have settled after reset
            next_vid_host[1:0] = {strap_b, strap_a}; // see RULE_15
        end
        if (is_write(reg_wr_in, reg_addr_in, spl_pkg::OFF_VID_HOST)) begin
            next_vid_host = reg_wdata_in & spl_pkg::MASK_VID_HOST; // see RULE_14 see RULE_16
        end
    end

    // strap capture waits out the two synchroniser stages
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    always_comb begin
        next_strap_cnt = strap_cnt;
        if (strap_cnt != 2'h3) begin
            next_strap_cnt = strap_cnt + 2'h1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tag_insert    <= spl_pkg::RST_TAG_INSERT;
            pwr_led       <= spl_pkg::RST_PWR_LED; // see RULE_11
            sleep_period  <= spl_pkg::RST_SLEEP;
            vid_host      <= spl_pkg::RST_VID_HOST;
            strap_pending <= 1'b0;
            strap_cnt     <= 2'h0;
        end else begin
            tag_insert    <= next_tag_insert;
            pwr_led       <= next_pwr_led;
            sleep_period  <= next_sleep_period;
            vid_host      <= next_vid_host;
            strap_pending <= (strap_cnt == 2'h2);
            strap_cnt     <= next_strap_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    logic [7:0] next_rdata;
    logic       next_hit;
    always_comb begin
        next_hit   = 1'b1;
        next_rdata = 8'h00;
        case (reg_addr_in)
            spl_pkg::OFF_TAG_INSERT: next_rdata = tag_insert;
            spl_pkg::OFF_PWR_LED:    next_rdata = pwr_led;
            spl_pkg::OFF_SLEEP:      next_rdata = sleep_period;
            spl_pkg::OFF_VID_HOST:   next_rdata = vid_host; // see RULE_16
            default:                 next_hit   = 1'b0;
        endcase
        if (!reg_rd_in) begin
            next_hit   = 1'b0;
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_hit_out   <= 1'b0;
        end else begin
            reg_rdata_out <= next_rdata;
            reg_hit_out   <= next_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs
    spl_pkg::spl_ctrl_t next_ctrl;
    always_comb begin
        next_ctrl.tag_insert   = tag_insert[5:0];                         // see RULE_01 see RULE_02
        next_ctrl.cpu_clk_off  = pwr_led[spl_pkg::POS_CPU_CLK_OFF];       // see RULE_03
        next_ctrl.sw_clk_off   = pwr_led[spl_pkg::POS_SW_CLK_OFF];        // see RULE_04
        next_ctrl.pll_off      = pwr_led[spl_pkg::POS_PLL_OFF];           // see RULE_09
        next_ctrl.pwr_mode     = spl_pkg::spl_pwr_mode_t'(pwr_led[spl_pkg::POS_PWR_MODE +: 2]); // see RULE_11
        next_ctrl.invalid_fwd  = vid_host[spl_pkg::POS_INVALID_FWD +: 3]; // see RULE_14
        next_ctrl.rmii_clk_int = vid_host[spl_pkg::POS_RMII_CLK_INT];
        next_ctrl.host_mode    = vid_host[spl_pkg::POS_HOST_MODE +: 2];   // see RULE_15
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ctrl_out <= '0;
        end else begin
            ctrl_out <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // energy-detect sleep timer
    // long unit counter kept as a parameter so simulation can shorten it
    logic [31:0] unit_cnt;
    logic [7:0]  period_cnt;
    logic        low_power;
    logic [31:0] next_unit_cnt;
    logic [7:0]  next_period_cnt;
    logic        next_low_power;
    logic        energy_sense_low_power;

    always_comb begin
        energy_sense_low_power         = (pwr_led[spl_pkg::POS_PWR_MODE +: 2] == 2'(spl_pkg::SPL_PWR_ENERGY));
        next_unit_cnt   = unit_cnt;
        next_period_cnt = period_cnt;
        next_low_power  = low_power;
        if (!energy_sense_low_power || energy_s) begin
            // any energy restarts the whole period
            next_unit_cnt   = 32'h0; // see RULE_13
            next_period_cnt = 8'h00;
            next_low_power  = 1'b0;
        end else if (!low_power) begin
            if (period_cnt >= sleep_period) begin
                next_low_power = 1'b1; // see RULE_12 see RULE_13
            end else if (unit_cnt == 32'(UNIT_CYCLES - 1)) begin
                next_unit_cnt   = 32'h0;
                next_period_cnt = period_cnt + 8'h01;
            end else begin
                next_unit_cnt = unit_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            unit_cnt      <= 32'h0;
            period_cnt    <= 8'h00;
            low_power     <= 1'b0;
            low_power_out <= 1'b0;
        end else begin
            unit_cnt      <= next_unit_cnt;
            period_cnt    <= next_period_cnt;
            low_power     <= next_low_power;
            low_power_out <= next_low_power;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status pins
    spl_led_drive u_led (
        .core_clk_in         (core_clk_in),
        .rst_in              (rst_in),
        .led_mode_in         (pwr_led[spl_pkg::POS_LED_MODE +: 2]), // see RULE_06
        .led_debug_in        (pwr_led[spl_pkg::POS_LED_DEBUG]),     // see RULE_08
        .energy_stretched_in (energy_str_s),
        .device_ready_in     (ready_s),
        .stat_in             (stat_sync),
        .status_pin_a_out    (status_pin_a_out),
        .status_pin_b_out    (status_pin_b_out)
    );
endmodule

// ==== spl_config_regs_assertions.sv ====
`timescale 1ns/10ps
module spl_config_regs_chk (
    // clock, reset and register port
    input wire logic               core_clk_in,
    input wire logic               rst_in,
    input wire logic               reg_wr_in,
    input wire logic               reg_rd_in,
    input wire logic [7:0]         reg_addr_in,
    input wire logic [7:0]         reg_wdata_in,
    input wire logic [7:0]         reg_rdata_out,
    input wire logic               reg_hit_out,
    // status and controls
    input wire logic               energy_in,
    input wire spl_pkg::spl_ctrl_t ctrl_out,
    input wire logic               low_power_out,
    input wire logic               status_pin_a_out,
    input wire logic               status_pin_b_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic mapped;
    assign mapped = reg_addr_in inside {spl_pkg::OFF_TAG_INSERT, spl_pkg::OFF_PWR_LED,
                                        spl_pkg::OFF_SLEEP, spl_pkg::OFF_VID_HOST};
    a_hit_mapped: assert property (reg_rd_in && mapped |=> reg_hit_out)
        else $error("mapped read gave no hit");
    a_unmapped_zero: assert property (reg_rd_in && !mapped |=> !reg_hit_out && reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_idle_rdata: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00 && !reg_hit_out)
        else $error("read data outside a read");
    a_tag_write: assert property (reg_wr_in && reg_addr_in == spl_pkg::OFF_TAG_INSERT
        |-> ##2 ctrl_out.tag_insert == $past(reg_wdata_in[5:0], 2)) else $error("tag insert control wrong");
    a_pwr_write: assert property (reg_wr_in && reg_addr_in == spl_pkg::OFF_PWR_LED
        |-> ##2 {ctrl_out.cpu_clk_off, ctrl_out.sw_clk_off, ctrl_out.pll_off, ctrl_out.pwr_mode}
            == {$past(reg_wdata_in[7:6], 2), $past(reg_wdata_in[2:0], 2)}) else $error("power control wrong");
    a_vid_write: assert property (reg_wr_in && reg_addr_in == spl_pkg::OFF_VID_HOST
        |-> ##2 {ctrl_out.invalid_fwd, ctrl_out.rmii_clk_int, ctrl_out.host_mode}
            == {$past(reg_wdata_in[6:3], 2), $past(reg_wdata_in[1:0], 2)}) else $error("vid host control wrong");
    a_rsv_vid: assert property (reg_rd_in && reg_addr_in == spl_pkg::OFF_VID_HOST
        |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[2] == 1'b0) else $error("reserved vid bits set");
    a_rsv_tag: assert property (reg_rd_in && reg_addr_in == spl_pkg::OFF_TAG_INSERT
        |=> reg_rdata_out[7:6] == 2'h0) else $error("reserved tag bits set");
    a_reset_dflt: assert property ($fell(rst_in) |-> ctrl_out == '0 && !low_power_out
        && status_pin_a_out && status_pin_b_out) else $error("reset defaults wrong");
    a_energy_wake: assert property (energy_in [*6] |-> !low_power_out)
        else $error("low power with energy present");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind spl_config_regs spl_config_regs_chk chk_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .energy_in(energy_in), .ctrl_out(ctrl_out), .low_power_out(low_power_out),
    .status_pin_a_out(status_pin_a_out), .status_pin_b_out(status_pin_b_out));

// ==== spl_pin_env.sv ====
`timescale 1ns/10ps
module spl_pin_env #(
    parameter logic STRAP_A = 1'b0,
    parameter logic STRAP_B = 1'b1
) (
    // pins from the device
    input  wire logic status_pin_a_in,
    input  wire logic status_pin_b_in,
    // strap levels and lamp view
    output logic      strap_a_out,
    output logic      strap_b_out,
    output logic      lit_a_out,
    output logic      lit_b_out
);
    // resistors hold the straps; lamps never drive them back
    assign strap_a_out = STRAP_A;
    assign strap_b_out = STRAP_B;
    assign lit_a_out = !status_pin_a_in;
    assign lit_b_out = !status_pin_b_in;
endmodule

// ==== switch_power_led_host_config_tb_top.sv ====
`timescale 1ns/10ps
module switch_power_led_host_config_tb_top;
    logic                    core_clk_in, rst_in, wr, rd, energy, e_str, dev_rdy, hit, lp, pa, pb, sa, sb, la, lb;
    logic [7:0]              addr, wdata, rdata, p;
    spl_pkg::spl_port_stat_t stat;
    spl_pkg::spl_ctrl_t      ctrl;
    int                      err_count, cmp_count;
    logic [7:0]              offs [4] = '{spl_pkg::OFF_TAG_INSERT, spl_pkg::OFF_PWR_LED, spl_pkg::OFF_SLEEP,
                                          spl_pkg::OFF_VID_HOST};
    logic [7:0]              msk [4] = '{spl_pkg::MASK_TAG_INSERT, 8'hFF, 8'hFF, spl_pkg::MASK_VID_HOST};
    logic [7:0]              pats [3] = '{8'hFF, 8'hA5, 8'h5A};
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // short sleep unit keeps the run brief
    spl_config_regs #(.UNIT_CYCLES(4)) dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit), .port2_status_pin_a_in(sa),
        .port2_status_pin_b_in(sb), .energy_in(energy), .energy_stretched_in(e_str), .device_ready_in(dev_rdy),
        .port_stat_in(stat), .ctrl_out(ctrl), .low_power_out(lp), .status_pin_a_out(pa), .status_pin_b_out(pb));
    spl_pin_env #(.STRAP_A(1'b0), .STRAP_B(1'b1)) env_u (
        .status_pin_a_in(pa), .status_pin_b_in(pb), .strap_a_out(sa), .strap_b_out(sb),
        .lit_a_out(la), .lit_b_out(lb));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t bit %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_ctrl(input spl_pkg::spl_ctrl_t got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t ctrl %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge core_clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        chk8(rdata, e);
        chk1(hit, h);
    endtask
    task automatic set_energy(input logic e);
        @(posedge core_clk_in);
        energy <= e;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_in = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
        energy = 1'b1; e_str = 1'b0; dev_rdy = 1'b1; stat = 4'h0;
        err_count = 0; cmp_count = 0;
        for (int r = 0; r < 2; r++) begin
            repeat (5) @(posedge core_clk_in);
            rst_in <= 1'b0;
            tick(6);
            // host mode bits already hold the strap load by the time of this read
            foreach (offs[j]) rd_chk(offs[j], (j == 2) ? 8'h50 : ((j == 3) ? 8'h02 : 8'h00), 1'b1);
            chk_ctrl(ctrl, 17'h00002);
            // straps b=1, a=0 give host mode 2
            rd_chk(spl_pkg::OFF_VID_HOST, 8'h02, 1'b1);
            foreach (pats[k]) begin
                foreach (offs[j]) wr_reg(offs[j], pats[k]);
                foreach (offs[j]) rd_chk(offs[j], pats[k] & msk[j], 1'b1);
                p = pats[k];
                chk_ctrl(ctrl, {p[5:0], p[7:6], p[2:0], p[6:3], p[1:0]});
            end
            wr_reg(8'hC5, 8'hFF);
            rd_chk(8'hC5, 8'h00, 1'b0);
            @(posedge core_clk_in);
            rst_in <= 1'b1;
        end
        @(posedge core_clk_in);
        rst_in <= 1'b0;
        tick(6);
        // debug view: both inputs high light both lamps; no link would leave them dark
        e_str <= 1'b1;
        wr_reg(spl_pkg::OFF_PWR_LED, 8'h08);
        tick(8);
        chk1(la, 1'b1);
        chk1(lb, 1'b1);
        for (int m = 0; m < 8; m++) begin
            stat <= (m < 4) ? 4'hC : 4'hB;
            wr_reg(spl_pkg::OFF_PWR_LED, {2'h0, m[1:0], 4'h0});
            tick(8);
            chk1(la, (m < 4) ? 1'b1 : m[0]);
            chk1(lb, (m < 4) ? (m == 0) : (m != 4));
        end
        // clock trees off set from normal mode; the bits reach ctrl with no check of traffic
        wr_reg(spl_pkg::OFF_PWR_LED, 8'hC0);
        tick(3);
        chk1(ctrl.cpu_clk_off, 1'b1);
        chk1(ctrl.sw_clk_off, 1'b1);
        // normal mode never sleeps
        set_energy(1'b0);
        tick(30);
        chk1(lp, 1'b0);
        set_energy(1'b1);
        wr_reg(spl_pkg::OFF_SLEEP, 8'h03);
        // pll off is asked for here together with energy-detect mode
        wr_reg(spl_pkg::OFF_PWR_LED, 8'h05);
        tick(4);
        chk1(ctrl.pll_off, 1'b1);
        set_energy(1'b0);
        tick(8);
        set_energy(1'b1);
        tick(4);
        set_energy(1'b0);
        tick(10);
        chk1(lp, 1'b0);
        tick(10);
        chk1(lp, 1'b1);
        set_energy(1'b1);
        tick(8);
        chk1(lp, 1'b0);
        close_out();
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule
